/* File: core/charge_count_and_supply_monitor.sv */
// charge counter and supply/temperature monitor behind an apb slave
// assumes an external converter that answers adc_start with adc_done
// and codes on the same clock; pulse pins are asynchronous
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module charge_count_and_supply_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pulse_a,
  input wire logic pulse_b,
  input wire logic pulse_c,
  input wire logic [1:0] energy_state,
  input wire logic cal_active,
  input wire logic [1:0] buckboost_mode_report,
  input wire logic [1:0] buckonly_mode_report,
  input wire logic input_pin_select_state,
  input wire logic refresh_tick,
  input wire logic adc_done,
  input wire logic [11:0] adc_supply_code,
  input wire logic [11:0] adc_temp_code,
  output logic adc_start,
  output logic supply_sel_secondary,
  output logic near_full_irq
);
  // ========================================================
  // functions
  function automatic logic [7:0] pick_byte(input logic [15:0] v,
                                           input logic low);
    pick_byte = low ? v[7:0] : v[15:8];
  endfunction

  function automatic logic [15:0] fill_level(input logic [1:0] sel);
    unique case (sel)
      2'h0: fill_level = cc_mon_pkg::FULL_50;
      2'h1: fill_level = cc_mon_pkg::FULL_62;
      2'h2: fill_level = cc_mon_pkg::FULL_75;
      2'h3: fill_level = cc_mon_pkg::FULL_87;
    endcase
  endfunction

  // ========================================================
  // pin synchronisers, edges taken from second and third stage
  logic [2:0] p1_r, p2_r, p3_r, p1_nxt, p2_nxt, p3_nxt;
  logic sel1_r, sel2_r, sel1_nxt, sel2_nxt;
  logic [2:0] edge_ev;

  always_comb begin
    p1_nxt = {pulse_c, pulse_b, pulse_a};
    p2_nxt = p1_r;
    p3_nxt = p2_r;
    sel1_nxt = input_pin_select_state;
    sel2_nxt = sel1_r;
    edge_ev = p2_r & ~p3_r;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      p1_r <= '0;
      p2_r <= '0;
      p3_r <= '0;
      sel1_r <= 1'b0;
      sel2_r <= 1'b0;
    end else begin
      p1_r <= p1_nxt;
      p2_r <= p2_nxt;
      p3_r <= p3_nxt;
      sel1_r <= sel1_nxt;
      sel2_r <= sel2_nxt;
    end
  end

  // ========================================================
  // charge counters: buck-only output split by sleep state
  logic [7:0] ctrl_r;
  logic count_clear_cmd_r;
  logic deep, light, cnt_en;
  logic [3:0] pair_pulse;
  logic [15:0] cc_res [4];

  assign deep = energy_state == cc_mon_pkg::ES_DEEP;
  assign light = energy_state == cc_mon_pkg::ES_LIGHT;
  // counting is not supported in deep sleep
  assign cnt_en = ctrl_r[cc_mon_pkg::CTRL_EN_BIT] && !deep;
  assign pair_pulse = {edge_ev[2], edge_ev[1] & light,
                       edge_ev[1] & ~light, edge_ev[0]};

  for (genvar g = 0; g < 4; g++) begin : g_pair
    charge_pair_counter #(.RESULT_W(16)) u_pair (
      .clk(clk),
      .reset(reset),
      .pulse(pair_pulse[g]),
      .count_en(cnt_en),
      .clear(count_clear_cmd_r),
      .cal_mode(g == 3 ? cal_active : 1'b0),
      .scale_sel(ctrl_r[cc_mon_pkg::CTRL_SCALE_LSB +: 3]),
      .result(cc_res[g])
    );
  end

  // ========================================================
  // monitor results
  logic tr_load, tr_reinit;
  logic [11:0] sup_r, tmp_r, temp_res_r;
  logic [11:0] avg_w, min_w, max_w;
  logic [7:0] monctl_r;

  supply_tracker #(.W(12)) u_track (
    .clk(clk),
    .reset(reset),
    .load(tr_load),
    .reinit(tr_reinit),
    .sample(sup_r),
    .tau(monctl_r[cc_mon_pkg::MONCTL_TAU_LSB +: 3]),
    .avg(avg_w),
    .lowest(min_w),
    .highest(max_w)
  );

  // ========================================================
  // apb slave and register file
  logic [7:0] unmask_r, vlim_r, tlim_r, shadow_r;
  logic [7:0] ctrl_nxt, unmask_nxt, monctl_nxt, vlim_nxt, tlim_nxt;
  logic [7:0] shadow_nxt;
  logic full_r, vlow_r, tfault_r, full_nxt, vlow_nxt, tfault_nxt;
  logic count_clear_cmd_nxt, start_pend_r, start_pend_nxt;
  logic mclr_pend_r, mclr_pend_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic irq_r, irq_nxt;
  logic [5:0] idx;
  logic setup, access, mapped, in_cc, in_mon, inhibit;
  logic wr_cmd, wr_stat, set_full, set_vlow, set_tfault, mon_start;
  logic [15:0] mon_pair [4];
  logic [15:0] lvl;
  logic [7:0] rd;

  assign idx = paddr[7:2];
  assign setup = psel && !penable;
  assign access = psel && penable && pready_r;
  assign mapped = idx <= cc_mon_pkg::REG_LAST;
  assign in_cc = idx >= cc_mon_pkg::REG_CC_BASE
                 && idx < cc_mon_pkg::REG_MON_BASE;
  assign in_mon = idx >= cc_mon_pkg::REG_MON_BASE && mapped;
  // holding off for the whole transfer keeps both bytes coherent
  assign inhibit = psel && in_mon;
  assign wr_cmd = access && pwrite && idx == cc_mon_pkg::REG_CMD;
  assign wr_stat = access && pwrite && idx == cc_mon_pkg::REG_STAT;
  // nibble in the high byte, eight bits in the low byte
  assign mon_pair[0] = {4'h0, avg_w};
  assign mon_pair[1] = {4'h0, min_w};
  assign mon_pair[2] = {4'h0, max_w};
  assign mon_pair[3] = {4'h0, temp_res_r};
  assign lvl = fill_level(ctrl_r[cc_mon_pkg::CTRL_THR_LSB +: 2]);
  // a crossing raises the flag; a cleared pair sits below any level
  assign set_full = cnt_en && (cc_res[0] >= lvl || cc_res[1] >= lvl
                    || cc_res[2] >= lvl || cc_res[3] >= lvl);

  // read data is fetched in setup so pready and prdata both register
  always_comb begin
    rd = 8'h00;
    unique case (1'b1)
      in_cc: rd = pick_byte(cc_res[idx[2:1]], idx[0]);
      in_mon: rd = idx[0] ? shadow_r
                          : pick_byte(mon_pair[idx[2:1]], 1'b0);
      default: begin
        case (idx)
          cc_mon_pkg::REG_CTRL: rd = ctrl_r;
          cc_mon_pkg::REG_STAT: rd = {5'h00, tfault_r, vlow_r, full_r};
          cc_mon_pkg::REG_UNMASK: rd = unmask_r;
          cc_mon_pkg::REG_MONCTL: rd = monctl_r;
          cc_mon_pkg::REG_VLIM: rd = vlim_r;
          cc_mon_pkg::REG_TLIM: rd = tlim_r;
          cc_mon_pkg::REG_MODE:
            rd = {3'h0, sel2_r, buckonly_mode_report,
                  buckboost_mode_report};
          default: rd = 8'h00;
        endcase
      end
    endcase
  end

  // register writes, one-shot commands and sticky flags
  always_comb begin
    ctrl_nxt = ctrl_r;
    unmask_nxt = unmask_r;
    monctl_nxt = monctl_r;
    vlim_nxt = vlim_r;
    tlim_nxt = tlim_r;
    shadow_nxt = shadow_r;
    pready_nxt = setup && !pready_r;
    pslverr_nxt = setup && !pready_r && !mapped;
    prdata_nxt = prdata_r;
    if (setup)
      prdata_nxt = {24'h000000, rd};
    if (access && pwrite && mapped) begin
      case (idx)
        cc_mon_pkg::REG_CTRL: ctrl_nxt = pwdata[7:0];
        cc_mon_pkg::REG_UNMASK: unmask_nxt = pwdata[7:0];
        cc_mon_pkg::REG_MONCTL: monctl_nxt = pwdata[7:0];
        cc_mon_pkg::REG_VLIM: vlim_nxt = pwdata[7:0];
        cc_mon_pkg::REG_TLIM: tlim_nxt = pwdata[7:0];
        default: ;
      endcase
    end
    // taking the high half snapshots its low byte
    if (access && !pwrite && in_mon && !idx[0])
      shadow_nxt = pick_byte(mon_pair[idx[2:1]], 1'b1);
    count_clear_cmd_nxt = wr_cmd && pwdata[cc_mon_pkg::CMD_COUNT_CLEAR_CMD];
    start_pend_nxt = (start_pend_r && !mon_start)
                     || (wr_cmd && pwdata[cc_mon_pkg::CMD_START]);
    mclr_pend_nxt = (mclr_pend_r && !tr_load)
                    || (wr_cmd && pwdata[cc_mon_pkg::CMD_MON_CLR]);
    // set wins over a write-one clear in the same cycle
    full_nxt = set_full || (full_r && !(wr_stat
               && pwdata[cc_mon_pkg::ST_FULL]));
    vlow_nxt = set_vlow || (vlow_r && !(wr_stat
               && pwdata[cc_mon_pkg::ST_VLOW]));
    tfault_nxt = set_tfault || (tfault_r && !(wr_stat
                 && pwdata[cc_mon_pkg::ST_TFAULT]));
    irq_nxt = full_nxt && unmask_r[cc_mon_pkg::UNMASK_FULL];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= cc_mon_pkg::CTRL_RST;
      unmask_r <= cc_mon_pkg::UNMASK_RST;
      monctl_r <= cc_mon_pkg::MONCTL_RST;
      vlim_r <= cc_mon_pkg::VLIM_RST;
      tlim_r <= cc_mon_pkg::TLIM_RST;
      shadow_r <= 8'h00;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      count_clear_cmd_r <= 1'b0;
      start_pend_r <= 1'b0;
      mclr_pend_r <= 1'b0;
      full_r <= 1'b0;
      vlow_r <= 1'b0;
      tfault_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      unmask_r <= unmask_nxt;
      monctl_r <= monctl_nxt;
      vlim_r <= vlim_nxt;
      tlim_r <= tlim_nxt;
      shadow_r <= shadow_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      count_clear_cmd_r <= count_clear_cmd_nxt;
      start_pend_r <= start_pend_nxt;
      mclr_pend_r <= mclr_pend_nxt;
      full_r <= full_nxt;
      vlow_r <= vlow_nxt;
      tfault_r <= tfault_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ========================================================
  // monitor triggering and conversion sequence
  cc_mon_pkg::mon_state_t state_r, state_nxt;
  logic [10:0] ev_cnt_r, ev_cnt_nxt, ev_span, ev_sum;
  logic [2:0] ref_cnt_r, ref_cnt_nxt, interval;
  logic auto_pend_r, auto_pend_nxt, adc_start_r, adc_start_nxt;
  logic sel_r, sel_nxt;
  logic [11:0] sup_nxt, tmp_nxt, temp_res_nxt;

  assign interval = monctl_r[cc_mon_pkg::MONCTL_INT_LSB +: 3];
  assign ev_span = 11'h001 << (interval + cc_mon_pkg::INT_OFFSET);
  assign ev_sum = ev_cnt_r + {10'h000, pair_pulse[0] & cnt_en}
                  + {10'h000, edge_ev[1] & cnt_en}
                  + {10'h000, pair_pulse[3] & cnt_en};
  // start only outside deep sleep, where the monitor is off
  assign mon_start = state_r == cc_mon_pkg::MON_IDLE && !deep
                     && (start_pend_r || auto_pend_r);
  assign tr_load = state_r == cc_mon_pkg::MON_STORE && !inhibit;
  assign tr_reinit = mclr_pend_r;
  assign set_vlow = tr_load && sup_r < {vlim_r, 4'h0};
  assign set_tfault = tr_load
                      && $signed(tmp_r) > $signed({tlim_r, 4'h0});

  always_comb begin
    state_nxt = state_r;
    ev_cnt_nxt = ev_cnt_r;
    ref_cnt_nxt = ref_cnt_r;
    auto_pend_nxt = auto_pend_r;
    adc_start_nxt = mon_start;
    sel_nxt = sel2_r;
    sup_nxt = sup_r;
    tmp_nxt = tmp_r;
    temp_res_nxt = temp_res_r;
    if (interval == 3'h0) begin
      ev_cnt_nxt = '0;
      ref_cnt_nxt = '0;
      auto_pend_nxt = 1'b0;
    end else begin
      if (ev_sum >= ev_span) begin
        ev_cnt_nxt = '0;
        auto_pend_nxt = 1'b1;
      end else begin
        ev_cnt_nxt = ev_sum;
      end
      if (refresh_tick) begin
        if (ref_cnt_r + 3'h1 >= cc_mon_pkg::REFRESH_PER_TRIG) begin
          ref_cnt_nxt = '0;
          auto_pend_nxt = 1'b1;
        end else begin
          ref_cnt_nxt = ref_cnt_r + 3'h1;
        end
      end
      if (mon_start) begin
        ref_cnt_nxt = '0;
        if (!(ev_sum >= ev_span))
          auto_pend_nxt = 1'b0;
      end
    end
    unique case (state_r)
      cc_mon_pkg::MON_IDLE: begin
        if (mon_start)
          state_nxt = cc_mon_pkg::MON_CONV;
      end
      cc_mon_pkg::MON_CONV: begin
        if (adc_done) begin
          sup_nxt = adc_supply_code;
          tmp_nxt = adc_temp_code;
          state_nxt = cc_mon_pkg::MON_STORE;
        end
      end
      cc_mon_pkg::MON_STORE: begin
        if (tr_load) begin
          temp_res_nxt = tmp_r;
          state_nxt = cc_mon_pkg::MON_IDLE;
        end
      end
      default: state_nxt = cc_mon_pkg::MON_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= cc_mon_pkg::MON_IDLE;
      ev_cnt_r <= '0;
      ref_cnt_r <= '0;
      auto_pend_r <= 1'b0;
      adc_start_r <= 1'b0;
      sel_r <= 1'b0;
      sup_r <= '0;
      tmp_r <= '0;
      temp_res_r <= '0;
    end else begin
      state_r <= state_nxt;
      ev_cnt_r <= ev_cnt_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      auto_pend_r <= auto_pend_nxt;
      adc_start_r <= adc_start_nxt;
      sel_r <= sel_nxt;
      sup_r <= sup_nxt;
      tmp_r <= tmp_nxt;
      temp_res_r <= temp_res_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign adc_start = adc_start_r;
  assign supply_sel_secondary = sel_r;
  assign near_full_irq = irq_r;
endmodule

/* File: pkg/cc_mon_pkg.sv */
// constants shared by the charge counter and supply monitor
// assumes an 8-bit register file, one register per aligned apb word
package cc_mon_pkg;
  // ========================================================
  // register indexes, byte address is four times the index
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_CMD = 6'h01;
  localparam logic [5:0] REG_STAT = 6'h02;
  localparam logic [5:0] REG_UNMASK = 6'h03;
  localparam logic [5:0] REG_MONCTL = 6'h04;
  localparam logic [5:0] REG_VLIM = 6'h05;
  localparam logic [5:0] REG_TLIM = 6'h06;
  localparam logic [5:0] REG_MODE = 6'h07;
  localparam logic [5:0] REG_CC_BASE = 6'h08;
  localparam logic [5:0] REG_MON_BASE = 6'h10;
  localparam logic [5:0] REG_LAST = 6'h17;
  // ========================================================
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SCALE_LSB = 1;
  localparam int CTRL_THR_LSB = 4;
  localparam int CMD_COUNT_CLEAR_CMD = 0;
  localparam int CMD_START = 1;
  localparam int CMD_MON_CLR = 2;
  localparam int ST_FULL = 0;
  localparam int ST_VLOW = 1;
  localparam int ST_TFAULT = 2;
  localparam int UNMASK_FULL = 0;
  localparam int MONCTL_TAU_LSB = 0;
  localparam int MONCTL_INT_LSB = 4;
  // ========================================================
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] UNMASK_RST = 8'h00;
  localparam logic [7:0] MONCTL_RST = 8'h00;
  localparam logic [7:0] VLIM_RST = 8'h00;
  localparam logic [7:0] TLIM_RST = 8'h7f;
  localparam logic [11:0] MIN_RST = 12'hfff;
  localparam logic [11:0] MAX_RST = 12'h000;
  // ========================================================
  // scaling, thresholds and trigger counts
  localparam logic [4:0] SCALE_EXP = 5'h10;
  localparam logic [15:0] FULL_50 = 16'h8000;
  localparam logic [15:0] FULL_62 = 16'ha000;
  localparam logic [15:0] FULL_75 = 16'hc000;
  localparam logic [15:0] FULL_87 = 16'hdeb8;
  localparam logic [3:0] INT_OFFSET = 4'h3;
  localparam logic [2:0] REFRESH_PER_TRIG = 3'h4;
  localparam int AVG_FRAC = 8;
  // energy states
  localparam logic [1:0] ES_ACTIVE = 2'h0;
  localparam logic [1:0] ES_LIGHT = 2'h1;
  localparam logic [1:0] ES_DEEP = 2'h2;
  typedef enum logic [2:0] {
    MON_IDLE = 3'b001,
    MON_CONV = 3'b010,
    MON_STORE = 3'b100
  } mon_state_t;
endpackage

/* File: core/charge_pair_counter.sv */
// one charge result pair with its pulse prescaler
// assumes pulse is a one-cycle event already in the clk domain
`timescale 1ns/1ns
module charge_pair_counter #(
  parameter int RESULT_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic pulse,
  input wire logic count_en,
  input wire logic clear,
  input wire logic cal_mode,
  input wire logic [2:0] scale_sel,
  output logic [RESULT_W-1:0] result
);
  if (RESULT_W < 8 || RESULT_W > 32) begin : g_bad_w
    $error("RESULT_W out of range");
  end

  logic [16:0] pre_r, pre_nxt;
  logic [RESULT_W-1:0] res_r, res_nxt;
  logic [4:0] shift;
  logic [16:0] span;

  // ========================================================
  // one count per 2^(16-2*sel) pulses; calibration counts clocks
  always_comb begin
    shift = cc_mon_pkg::SCALE_EXP - {1'b0, scale_sel, 1'b0};
    span = 17'h00001 << shift;
    pre_nxt = pre_r;
    res_nxt = res_r;
    if (clear) begin
      pre_nxt = '0;
      res_nxt = '0;
    end else if (cal_mode) begin
      res_nxt = res_r + 1'b1; // unscaled clock count
    end else if (count_en && pulse) begin
      if (pre_r + 17'h00001 == span) begin
        pre_nxt = '0;
        res_nxt = res_r + 1'b1;
      end else begin
        pre_nxt = pre_r + 17'h00001;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_r <= '0;
      res_r <= '0;
    end else begin
      pre_r <= pre_nxt;
      res_r <= res_nxt;
    end
  end

  assign result = res_r;
endmodule

/* File: core/supply_tracker.sv */
// iir average, lowest and highest of the supply readings
// assumes load is a one-cycle strobe with a stable sample
`timescale 1ns/1ns
module supply_tracker #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic reinit,
  input wire logic [W-1:0] sample,
  input wire logic [2:0] tau,
  output logic [W-1:0] avg,
  output logic [W-1:0] lowest,
  output logic [W-1:0] highest
);
  localparam int F = cc_mon_pkg::AVG_FRAC;
  if (W != 12) begin : g_bad_w
    $error("W must be 12");
  end

  logic [W+F-1:0] acc_r, acc_nxt;
  logic [W-1:0] min_r, min_nxt, max_r, max_nxt;
  logic signed [W+F:0] diff;

  // ========================================================
  // fractional bits keep slow filters from stalling short of input
  always_comb begin
    diff = $signed({1'b0, sample, {F{1'b0}}}) - $signed({1'b0, acc_r});
    acc_nxt = acc_r;
    min_nxt = min_r;
    max_nxt = max_r;
    if (load && reinit) begin
      acc_nxt = {sample, {F{1'b0}}};
      min_nxt = sample;
      max_nxt = sample;
    end else if (load) begin
      acc_nxt = acc_r + (W+F)'(diff >>> tau);
      if (sample < min_r)
        min_nxt = sample;
      if (sample > max_r)
        max_nxt = sample;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_r <= '0;
      min_r <= cc_mon_pkg::MIN_RST;
      max_r <= cc_mon_pkg::MAX_RST;
    end else begin
      acc_r <= acc_nxt;
      min_r <= min_nxt;
      max_r <= max_nxt;
    end
  end

  assign avg = acc_r[W+F-1:F];
  assign lowest = min_r;
  assign highest = max_r;
endmodule

/* File: verif/cc_mon_props.sv */
// assertions on the apb slave, readout shape and monitor start
// assumes it is bound into the top module and sees only its ports
`timescale 1ns/1ns
module cc_mon_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] energy_state,
  input wire logic input_pin_select_state,
  input wire logic adc_start,
  input wire logic supply_sel_secondary
);
  // ==================================================
  // properties, one clock domain so defaults are shared
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err;
    pready |-> pslverr == (paddr[7:2] > cc_mon_pkg::REG_LAST);
  endproperty
  a_err: assert property (p_err) else $error("wrong error flag");
  property p_hi; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  // a monitor high register holds only a nibble
  property p_nib;
    pready && !pwrite && paddr[7:5] == 3'h2 && !paddr[2]
      |-> prdata[7:4] == 4'h0;
  endproperty
  a_nib: assert property (p_nib) else $error("nibble overflow");
  property p_start; adc_start |=> !adc_start; endproperty
  a_start: assert property (p_start) else $error("start too long");
  property p_deep;
    (energy_state == cc_mon_pkg::ES_DEEP) [*2] |=> !adc_start;
  endproperty
  a_deep: assert property (p_deep) else $error("start in deep");
  // five samples cover the three-stage synchroniser lag
  property p_sel; input_pin_select_state [*5] |-> supply_sel_secondary;
  endproperty
  a_sel: assert property (p_sel) else $error("pin select lost");
  c_wr: cover property (psel && penable && pwrite && pready);
  c_err: cover property (pready && pslverr);
  c_start: cover property (adc_start);
endmodule
bind charge_count_and_supply_monitor cc_mon_props cc_mon_props_inst (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .energy_state(energy_state), .adc_start(adc_start),
  .input_pin_select_state(input_pin_select_state),
  .supply_sel_secondary(supply_sel_secondary));

/* File: verif/adc_model.sv */
// converter stand-in: answers each start with done and two codes
// assumes start is a one-cycle pulse; the bench sets codes and latency
`timescale 1ns/1ns
module adc_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic adc_start,
  input wire logic [11:0] sup,
  input wire logic [11:0] tmp,
  input wire logic [3:0] lat,
  output logic adc_done,
  output logic [11:0] adc_supply_code,
  output logic [11:0] adc_temp_code
);
  // ==================================================
  // conversion timer
  logic busy_r;
  logic [3:0] cnt_r;
  // codes mean nothing outside done, so they toggle every cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_r <= 1'h0;
      cnt_r <= 4'h0;
      adc_done <= 1'h0;
      adc_supply_code <= 12'h000;
      adc_temp_code <= 12'h000;
    end else begin
      adc_done <= 1'h0;
      adc_supply_code <= ~adc_supply_code;
      adc_temp_code <= ~adc_temp_code;
      if (adc_start) begin
        busy_r <= 1'h1;
        cnt_r <= lat;
      end else if (busy_r && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (busy_r) begin
        busy_r <= 1'h0;
        adc_done <= 1'h1;
        adc_supply_code <= sup;
        adc_temp_code <= tmp;
      end
    end
  end
endmodule

/* File: verif/tb.sv */
// self-checking bench for the charge counter and supply monitor
// assumes the converter model answers every conversion start
`timescale 1ns/1ns
module tb;
  logic clk, reset, psel, penable, pwrite, pulse_a, cal_active;
  logic refresh_tick, sel_state, pready, pslverr, adc_start, adc_done;
  logic supply_sel_secondary, near_full_irq;
  logic [1:0] energy_state;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] sup, tmp, s_code, t_code;
  logic [3:0] lat;
  int error_cnt, n_compared, n_start, n_done;
  charge_count_and_supply_monitor charge_count_and_supply_monitor_inst (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulse_a(pulse_a),
    .pulse_b(1'h0), .pulse_c(1'h0), .energy_state(energy_state),
    .cal_active(cal_active), .buckboost_mode_report(2'h2),
    .buckonly_mode_report(2'h1), .input_pin_select_state(sel_state),
    .refresh_tick(refresh_tick), .adc_done(adc_done),
    .adc_supply_code(s_code), .adc_temp_code(t_code),
    .adc_start(adc_start), .supply_sel_secondary(supply_sel_secondary),
    .near_full_irq(near_full_irq));
  adc_model adc_model_inst (.clk(clk), .reset(reset),
    .adc_start(adc_start), .sup(sup), .tmp(tmp), .lat(lat),
    .adc_done(adc_done), .adc_supply_code(s_code), .adc_temp_code(t_code));
  // ==================================================
  // clock and event counters
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (adc_start === 1'h1) n_start++;
    if (adc_done === 1'h1) n_done++;
  end
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic hang();
    error_cnt++;
    $display("Error wait expected answer seen none");
    close_out();
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until ready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [5:0] i,
      input logic [7:0] d, output logic [7:0] r, output logic e);
    int k;
    k = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      if (++k > 20) hang();
    end while (pready !== 1'h1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'h1, i, d, r, e);
  endtask
  task automatic creg(input string nm, input logic [5:0] i,
      input logic [7:0] x);
    logic [7:0] r;
    logic e;
    apb(1'h0, i, 8'h00, r, e);
    chk(nm, {7'h0, i > cc_mon_pkg::REG_LAST, x}, {7'h0, e, r});
  endtask
  // high byte first, so a monitor pair's low byte comes from the snapshot
  task automatic c16(input string nm, input logic [5:0] i,
      input logic [15:0] x);
    logic [15:0] v;
    logic e;
    apb(1'h0, i, 8'h00, v[15:8], e);
    apb(1'h0, i + 6'h01, 8'h00, v[7:0], e);
    chk(nm, x, v);
  endtask
  task automatic pls(input int n);
    repeat (n) begin
      pulse_a <= 1'h1;
      repeat (2) @(posedge clk);
      pulse_a <= 1'h0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic wfor(input logic dn, input int n);
    int k;
    k = 0;
    while ((dn ? n_done : n_start) == n) begin
      if (++k > 40) hang();
      @(negedge clk);
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic trig(input logic [7:0] c, input logic [11:0] s, t,
      input logic [3:0] l);
    int n;
    n = n_done;
    sup <= s;
    tmp <= t;
    lat <= l;
    wr(6'h01, c);
    wfor(1'h1, n);
  endtask
  // ==================================================
  // scenarios
  task automatic s_regs();
    creg("tlim", cc_mon_pkg::REG_TLIM, cc_mon_pkg::TLIM_RST);
    creg("unmask", cc_mon_pkg::REG_UNMASK, 8'h00);
    creg("min_hi", 6'h12, 8'h0f);
    creg("mode", cc_mon_pkg::REG_MODE, 8'h16);
    creg("unmapped", 6'h20, 8'h00);
  endtask
  task automatic s_count();
    wr(6'h00, 8'h0f);
    pls(8);
    c16("cnt", 6'h08, 16'h0002);
    energy_state <= cc_mon_pkg::ES_DEEP;
    pls(4);
    energy_state <= cc_mon_pkg::ES_ACTIVE;
    wr(6'h00, 8'h0e);
    pls(4);
    c16("cnt_off", 6'h08, 16'h0002);
    wr(6'h01, 8'h01);
    c16("cnt_clr", 6'h08, 16'h0000);
  endtask
  task automatic s_full();
    wr(6'h00, 8'h01);
    cal_active <= 1'h1;
    repeat (32800) @(posedge clk);
    cal_active <= 1'h0;
    creg("stat", 6'h02, 8'h01);
    chk("irq_off", 16'h0, {15'h0, near_full_irq});
    wr(6'h03, 8'h01);
    @(posedge clk);
    chk("irq", 16'h1, {15'h0, near_full_irq});
    creg("cal_hi", 6'h0e, 8'h80);
    wr(6'h00, 8'h00);
    wr(6'h01, 8'h01);
    creg("stat_kept", 6'h02, 8'h01);
    wr(6'h02, 8'h01);
    chk("irq_clr", 16'h0, {15'h0, near_full_irq});
  endtask
  task automatic s_mon();
    trig(8'h06, 12'h345, 12'h123, 4'h0);
    c16("avg", 6'h10, 16'h0345);
    c16("max", 6'h14, 16'h0345);
    c16("temp", 6'h16, 16'h0123);
    wr(6'h05, 8'h20);
    trig(8'h02, 12'h100, 12'h0f0, 4'h9);
    c16("min", 6'h12, 16'h0100);
    c16("max2", 6'h14, 16'h0345);
    c16("temp2", 6'h16, 16'h00f0);
    creg("vlow", 6'h02, 8'h02);
  endtask
  task automatic s_auto();
    int ns, nd;
    ns = n_start;
    nd = n_done;
    wr(6'h04, 8'h10);
    refresh_tick <= 1'h1;
    repeat (4) @(posedge clk);
    refresh_tick <= 1'h0;
    repeat (3) @(posedge clk);
    wfor(1'h0, ns);
    wfor(1'h1, nd);
    nd = n_done;
    wr(6'h00, 8'h01);
    pls(16);
    wfor(1'h1, nd);
    wr(6'h04, 8'h00);
    ns = n_start;
    refresh_tick <= 1'h1;
    repeat (8) @(posedge clk);
    refresh_tick <= 1'h0;
    repeat (9) @(posedge clk);
    chk("no_auto", 16'h0, 16'(n_start - ns));
  endtask
  // ==================================================
  // main sequence
  initial begin
    reset = 1'h1;
    {psel, penable, pwrite, pulse_a, cal_active, refresh_tick} = 6'h00;
    sel_state = 1'h1;
    energy_state = cc_mon_pkg::ES_ACTIVE;
    paddr = 8'h00;
    pwdata = 32'h0;
    {sup, tmp, lat} = 28'h0;
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    s_regs();
    s_count();
    s_full();
    s_mon();
    s_auto();
    close_out();
  end
endmodule
